// File: src/fpvc_device.sv
/*
  Data manager end: packs outgoing records, checks incoming records,
  takes event texts; Wishbone classic slave with sticky events.
  Assumes the master end shares core_clk and obeys the link framing.
*/
// Functional notes
// R1 - empty slots produce no configuration bytes; an empty last slot still sends an FFH filler byte
// R2 - analog record is float plus status, five bytes
// R3 - float bytes MSB first, status last
// R4 - sign bit, exponent, mantissa octet layout
// R5 - value is sign times 1.M times 2^(E-127)
// R6 - bad statuses 10H, 11H, 12H, 18H; the code also sends 13H (class 0, limit bits 3)
// R7 - uncertain 48H plus limit bits
// R8 - good 80H plus limit bits
// R9 - incoming 80H..FFH used as good
// R10 - incoming 40H..7FH used, error flagged
// R11 - incoming 00H..3FH rejected
// R12 - digital status is two bytes
// R13 - first byte bit is channel level
// R14 - second byte bit is active; inactive levels ignored
// R15 - each output bit maps to chosen channel
// R16 - only fieldbus-typed channels take master bits
// R17 - event texts at most 40 characters
// R18 - texts written at slot 0 index 0
`default_nettype none
module fpvc_device (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // link
  fpvc_link_if.device      link,
  // wishbone slave
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [7:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatW,
  output logic      [31:0] wbDatR,
  output logic             wbAck,
  // interrupt
  output logic             irq
);
  import fpvc_pkg::*;

  typedef enum logic [1:0] {
    FPVC_TX_IDLE = 2'b00,
    FPVC_TX_ANA  = 2'b01,
    FPVC_TX_DIG  = 2'b10,
    FPVC_TX_CFG  = 2'b11
  } fpvc_tx_t;

  typedef struct packed {
    logic [31:0]             ain;       // last accepted analog value
    logic [7:0]              ainSt;
    logic [7:0]              dinLvl;
    logic [31:0]             rxShift;
    logic [2:0]              rxCnt;
    logic [31:0]             aout;
    logic [1:0]              aoutCls;   // 0 bad,1 uncertain,2 good
    logic [1:0]              aoutLim;
    logic [7:0]              doutLvl;
    logic [7:0]              doutAct;
    logic [23:0]             chanMap;   // 3 bits per output bit
    logic [7:0]              chanBus;   // channel has fieldbus function type
    logic [7:0]              slots;     // 2 bits per slot kind
    logic [FPVC_EV_W-1:0]    stat;
    logic [FPVC_EV_W-1:0]    mask;
    logic [5:0]              textLen;
    logic [7:0]              textHead;
    fpvc_tx_t                tx;
    logic [2:0]              txCnt;
    logic [1:0]              txSlot;
    logic                    dmValid;
    logic [7:0]              dmData;
    logic                    dmLast;
    fpvc_frame_t             dmKind;
    logic [31:0]             wbDatR;
    logic                    wbAck;
    logic                    irq;
  } fpvc_dev_t;

  fpvc_dev_t s_q, s_d;

  function automatic logic [7:0] outStatus(input logic [1:0] cls, input logic [1:0] lim);
    case (cls)
      2'd2:    outStatus = FPVC_ST_GOOD | {6'h00, lim};   // R8
      2'd1:    outStatus = FPVC_ST_UNCERT | {6'h00, lim}; // R7
      2'd3:    outStatus = FPVC_ST_UNDEF;                 // R6
      default: outStatus = {6'h04, lim};                  // R6
    endcase
  endfunction

  function automatic logic [7:0] byteOf(input logic [31:0] v, input logic [2:0] i);
    byteOf = v[31 - 8*i -: 8];                            // R3 R4 R5
  endfunction

  logic        wbHit;
  logic [31:0] rdMux;
  logic        mdText;

  always_comb begin
    wbHit = wbCyc && wbStb && !s_q.wbAck;
    case (wbAdr)
      FPVC_R_CTRL:   rdMux = {s_q.chanBus, s_q.chanMap};
      FPVC_R_STAT:   rdMux = {26'h0, s_q.stat};
      FPVC_R_MASK:   rdMux = {26'h0, s_q.mask};
      FPVC_R_AIN:    rdMux = s_q.ain;
      FPVC_R_AINST:  rdMux = {24'h0, s_q.ainSt};
      FPVC_R_DIN:    rdMux = {24'h0, s_q.dinLvl};
      FPVC_R_AOUT:   rdMux = s_q.aout;
      FPVC_R_AOUTST: rdMux = {28'h0, s_q.aoutLim, s_q.aoutCls};
      FPVC_R_DOUT:   rdMux = {16'h0, s_q.doutAct, s_q.doutLvl};
      FPVC_R_TEXT:   rdMux = {18'h0, s_q.textHead, s_q.textLen};
      FPVC_R_SLOTS:  rdMux = {24'h0, s_q.slots};
      default:       rdMux = 32'h0000_0000;
    endcase
    mdText = link.mdValid && link.mdKind == FPVC_FR_TEXT;
  end

  always_comb begin
    s_d = s_q;
    s_d.wbAck = wbHit;
    s_d.wbDatR = wbHit ? rdMux : 32'h0000_0000;
    // clear before the event sets below, so a set in the same cycle wins
    if (wbHit && wbWe && wbSel == 4'hF && wbAdr == FPVC_R_STAT)
      s_d.stat = s_q.stat & ~wbDatW[FPVC_EV_W-1:0];
    // receive
    if (link.mdValid && link.mdKind == FPVC_FR_ANA) begin
      if (!link.mdLast) begin
        s_d.rxShift = {s_q.rxShift[23:0], link.mdData};   // R3
        s_d.rxCnt = s_q.rxCnt + 3'd1;
      end else begin
        s_d.rxCnt = 3'd0;
        if (s_q.rxCnt == 3'd4) begin                      // R2
          if (link.mdData >= FPVC_IN_GOOD_MIN) begin      // R9
            s_d.ain = s_q.rxShift;
            s_d.ainSt = link.mdData;
            s_d.stat[FPVC_EV_GOOD] = 1'b1;
          end else if (link.mdData >= FPVC_IN_UNC_MIN) begin
            s_d.ain = s_q.rxShift;                        // R10
            s_d.ainSt = link.mdData;
            s_d.stat[FPVC_EV_UNC] = 1'b1;
          end else begin
            s_d.stat[FPVC_EV_BAD] = 1'b1;                 // R11
          end
        end else begin
          s_d.stat[FPVC_EV_BAD] = 1'b1;
        end
      end
    end
    if (link.mdValid && link.mdKind == FPVC_FR_DIG) begin
      if (!link.mdLast) begin
        s_d.rxShift = {s_q.rxShift[23:0], link.mdData};   // R13
        s_d.rxCnt = s_q.rxCnt + 3'd1;
      end else begin
        s_d.rxCnt = 3'd0;
        if (s_q.rxCnt == 3'd1) begin                      // R12
          for (int b = 0; b < FPVC_DIG_CHANS; b++) begin
            // R14 R15 R16
            if (link.mdData[b] && s_q.chanBus[s_q.chanMap[3*b +: 3]])
              s_d.dinLvl[s_q.chanMap[3*b +: 3]] = s_q.rxShift[b];
          end
          s_d.stat[FPVC_EV_DIG] = 1'b1;
        end
      end
    end
    if (mdText) begin                                     // R18
      if (s_q.textLen == 6'd0)
        s_d.textHead = link.mdData;
      if (s_q.textLen >= 6'(FPVC_TEXT_MAX)) begin
        s_d.stat[FPVC_EV_TOOLONG] = 1'b1;                 // R17
      end else begin
        s_d.textLen = s_q.textLen + 6'd1;
      end
      if (link.mdLast) begin
        if (s_q.textLen < 6'(FPVC_TEXT_MAX))
          s_d.stat[FPVC_EV_TEXT] = 1'b1;
        s_d.textLen = 6'd0;
      end
    end
    // transmit
    s_d.dmValid = 1'b0;
    s_d.dmLast = 1'b0;
    case (s_q.tx)
      FPVC_TX_ANA: begin
        s_d.dmValid = 1'b1;
        s_d.dmKind = FPVC_FR_ANA;
        s_d.dmData = (s_q.txCnt == 3'd4) ? outStatus(s_q.aoutCls, s_q.aoutLim)
                                         : byteOf(s_q.aout, s_q.txCnt);
        s_d.dmLast = s_q.txCnt == 3'(FPVC_ANA_BYTES - 1);
        s_d.txCnt = s_q.txCnt + 3'd1;
        if (s_d.dmLast) s_d.tx = FPVC_TX_IDLE;
      end
      FPVC_TX_DIG: begin
        s_d.dmValid = 1'b1;
        s_d.dmKind = FPVC_FR_DIG;
        s_d.dmData = (s_q.txCnt == 3'd0) ? s_q.doutLvl : s_q.doutAct;
        s_d.dmLast = s_q.txCnt == 3'(FPVC_DIG_BYTES - 1);
        s_d.txCnt = s_q.txCnt + 3'd1;
        if (s_d.dmLast) s_d.tx = FPVC_TX_IDLE;
      end
      FPVC_TX_CFG: begin
        // R1
        s_d.txSlot = s_q.txSlot + 2'd1;
        if (s_q.slots[2*s_q.txSlot +: 2] != FPVC_SLOT_EMPTY) begin
          s_d.dmValid = 1'b1;
          s_d.dmKind = FPVC_FR_CFG;
          s_d.dmData = {4'h0, 2'(s_q.txSlot), s_q.slots[2*s_q.txSlot +: 2]};
        end
        if (s_q.txSlot == 2'(FPVC_SLOTS - 1)) begin
          s_d.dmLast = 1'b1;
          s_d.dmValid = 1'b1;
          s_d.dmKind = FPVC_FR_CFG;
          if (s_q.slots[2*s_q.txSlot +: 2] == FPVC_SLOT_EMPTY) s_d.dmData = 8'hFF;
          s_d.tx = FPVC_TX_IDLE;
        end
      end
      default: ;
    endcase
    // bus writes
    if (wbHit && wbWe && wbSel == 4'hF) begin
      case (wbAdr)
        FPVC_R_CTRL: begin
          s_d.chanMap = wbDatW[23:0];
          s_d.chanBus = wbDatW[31:24];
        end
        FPVC_R_MASK:   s_d.mask = wbDatW[FPVC_EV_W-1:0];
        FPVC_R_AOUT:   s_d.aout = wbDatW;
        FPVC_R_AOUTST: begin
          s_d.aoutCls = wbDatW[1:0];
          s_d.aoutLim = wbDatW[3:2];
          if (s_q.tx == FPVC_TX_IDLE) begin
            s_d.tx = FPVC_TX_ANA;
            s_d.txCnt = 3'd0;
          end
        end
        FPVC_R_DOUT: begin
          s_d.doutLvl = wbDatW[7:0];
          s_d.doutAct = wbDatW[15:8];
          if (s_q.tx == FPVC_TX_IDLE) begin
            s_d.tx = FPVC_TX_DIG;
            s_d.txCnt = 3'd0;
          end
        end
        FPVC_R_SLOTS: begin
          s_d.slots = wbDatW[7:0];
          if (s_q.tx == FPVC_TX_IDLE) begin
            s_d.tx = FPVC_TX_CFG;
            s_d.txSlot = 2'd0;
          end
        end
        default: ;
      endcase
    end
    s_d.irq = |(s_d.stat & s_d.mask);
    if (!rst_n) begin
      s_d = '0;
      s_d.chanMap = FPVC_CTRL_RST[23:0];
    end
  end

  always_ff @(posedge core_clk) begin
    s_q <= s_d;
  end

  assign link.dmValid = s_q.dmValid;
  assign link.dmData  = s_q.dmData;
  assign link.dmLast  = s_q.dmLast;
  assign link.dmKind  = s_q.dmKind;
  assign wbDatR       = s_q.wbDatR;
  assign wbAck        = s_q.wbAck;
  assign irq          = s_q.irq;
endmodule
`default_nettype wire

// File: src/fpvc_link_if.sv
/*
  Byte link between the data manager end and the master end.
  Assumes one clock; each direction is a byte stream with valid, last and kind.
*/
`default_nettype none
interface fpvc_link_if;
  import fpvc_pkg::*;
  // master -> device
  logic        mdValid;
  logic [7:0]  mdData;
  logic        mdLast;
  fpvc_frame_t mdKind;
  // device -> master
  logic        dmValid;
  logic [7:0]  dmData;
  logic        dmLast;
  fpvc_frame_t dmKind;
  modport device (input mdValid, mdData, mdLast, mdKind,
                  output dmValid, dmData, dmLast, dmKind);
  modport master (output mdValid, mdData, mdLast, mdKind,
                  input dmValid, dmData, dmLast, dmKind);
endinterface
`default_nettype wire

// File: src/fpvc_master.sv
/*
  Master end: sends analog and digital records and event texts,
  decodes records arriving from the device.
  Assumes the device end shares core_clk; user pulses one request at a time.
*/
`default_nettype none
module fpvc_master (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // link
  fpvc_link_if.master      link,
  // user requests
  input  wire logic        sendAna,
  input  wire logic [31:0] anaValue,
  input  wire logic [7:0]  anaStatus,
  input  wire logic        sendDig,
  input  wire logic [7:0]  digLevel,
  input  wire logic [7:0]  digActive,
  input  wire logic        textPush,
  input  wire logic [7:0]  textChar,
  input  wire logic        textEnd,
  // user results
  output logic             busy,
  output logic             rxAnaValid,
  output logic      [31:0] rxAnaValue,
  output logic      [7:0]  rxAnaStatus,
  output logic             rxDigValid,
  output logic      [7:0]  rxDigLevel,
  output logic      [7:0]  rxDigActive
);
  import fpvc_pkg::*;

  typedef struct packed {
    logic [39:0]  txBuf;
    logic [2:0]   txLeft;
    logic         busy;
    fpvc_frame_t  txKind;
    logic [5:0]   textCnt;
    logic         mdValid;
    logic [7:0]   mdData;
    logic         mdLast;
    fpvc_frame_t  mdKind;
    logic [31:0]  rxShift;
    logic         rxAnaValid;
    logic [31:0]  rxAnaValue;
    logic [7:0]   rxAnaStatus;
    logic         rxDigValid;
    logic [7:0]   rxDigLevel;
    logic [7:0]   rxDigActive;
  } fpvc_mst_t;

  fpvc_mst_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.mdValid = 1'b0;
    s_d.mdLast = 1'b0;
    s_d.rxAnaValid = 1'b0;
    s_d.rxDigValid = 1'b0;
    if (s_q.txLeft != 3'd0) begin
      s_d.mdValid = 1'b1;
      s_d.mdKind = s_q.txKind;
      s_d.mdData = s_q.txBuf[39:32];                    // R3
      s_d.txBuf = {s_q.txBuf[31:0], 8'h00};
      s_d.txLeft = s_q.txLeft - 3'd1;
      s_d.mdLast = s_q.txLeft == 3'd1;
    end else if (sendAna) begin
      s_d.txBuf = {anaValue, anaStatus};                // R2 R4 R5
      s_d.txLeft = 3'(FPVC_ANA_BYTES);
      s_d.txKind = FPVC_FR_ANA;
    end else if (sendDig) begin
      s_d.txBuf = {digLevel, digActive, 24'h000000};    // R12 R13 R14
      s_d.txLeft = 3'(FPVC_DIG_BYTES);
      s_d.txKind = FPVC_FR_DIG;
    end else if (textPush) begin
      // R17 R18
      if (s_q.textCnt < 6'(FPVC_TEXT_MAX)) begin
        s_d.mdValid = 1'b1;
        s_d.mdKind = FPVC_FR_TEXT;
        s_d.mdData = textChar;
        // the fortieth character closes the frame; later ones are dropped
        s_d.mdLast = textEnd || s_q.textCnt == 6'(FPVC_TEXT_MAX - 1);
        s_d.textCnt = s_q.textCnt + 6'd1;
      end
      if (textEnd) s_d.textCnt = 6'd0;
    end
    if (link.dmValid) begin
      s_d.rxShift = {s_q.rxShift[23:0], link.dmData};
      if (link.dmLast && link.dmKind == FPVC_FR_ANA) begin
        s_d.rxAnaValid = 1'b1;
        s_d.rxAnaValue = s_q.rxShift;
        s_d.rxAnaStatus = link.dmData;
      end
      if (link.dmLast && link.dmKind == FPVC_FR_DIG) begin
        s_d.rxDigValid = 1'b1;
        s_d.rxDigLevel = s_q.rxShift[7:0];
        s_d.rxDigActive = link.dmData;
      end
    end
    s_d.busy = s_d.txLeft != 3'd0;
    if (!rst_n) s_d = '0;
  end

  always_ff @(posedge core_clk) begin
    s_q <= s_d;
  end

  assign link.mdValid = s_q.mdValid;
  assign link.mdData  = s_q.mdData;
  assign link.mdLast  = s_q.mdLast;
  assign link.mdKind  = s_q.mdKind;
  assign busy         = s_q.busy;
  assign rxAnaValid   = s_q.rxAnaValid;
  assign rxAnaValue   = s_q.rxAnaValue;
  assign rxAnaStatus  = s_q.rxAnaStatus;
  assign rxDigValid   = s_q.rxDigValid;
  assign rxDigLevel   = s_q.rxDigLevel;
  assign rxDigActive  = s_q.rxDigActive;
endmodule
`default_nettype wire

// File: src/fpvc_pkg.sv
/*
  Shared constants and types for the process-value codec: record layouts,
  status codes, slot kinds and acyclic addressing.
  Assumes both ends are clocked by one core_clk with a synchronous reset.
*/
`default_nettype none
package fpvc_pkg;
  localparam int          FPVC_SLOTS       = 4;
  localparam int          FPVC_ANA_BYTES   = 5;
  localparam int          FPVC_DIG_BYTES   = 2;
  localparam int          FPVC_DIG_CHANS   = 8;
  localparam int          FPVC_TEXT_MAX    = 40;
  localparam int          FPVC_EXP_BIAS    = 127;
  localparam logic [7:0]  FPVC_TEXT_SLOT   = 8'h00;
  localparam logic [7:0]  FPVC_TEXT_INDEX  = 8'h00;
  // outgoing status codes
  localparam logic [7:0]  FPVC_ST_OPEN     = 8'h10;
  localparam logic [7:0]  FPVC_ST_LOW      = 8'h11;
  localparam logic [7:0]  FPVC_ST_HIGH     = 8'h12;
  localparam logic [7:0]  FPVC_ST_UNDEF    = 8'h18;
  localparam logic [7:0]  FPVC_ST_UNCERT   = 8'h48;
  localparam logic [7:0]  FPVC_ST_GOOD     = 8'h80;
  // incoming status class bounds
  localparam logic [7:0]  FPVC_IN_GOOD_MIN = 8'h80;
  localparam logic [7:0]  FPVC_IN_UNC_MIN  = 8'h40;
  // register offsets of the device bus slave
  localparam logic [7:0]  FPVC_R_CTRL      = 8'h00;
  localparam logic [7:0]  FPVC_R_STAT      = 8'h04;
  localparam logic [7:0]  FPVC_R_MASK      = 8'h08;
  localparam logic [7:0]  FPVC_R_AIN       = 8'h0C;
  localparam logic [7:0]  FPVC_R_AINST     = 8'h10;
  localparam logic [7:0]  FPVC_R_DIN       = 8'h14;
  localparam logic [7:0]  FPVC_R_AOUT      = 8'h18;
  localparam logic [7:0]  FPVC_R_AOUTST    = 8'h1C;
  localparam logic [7:0]  FPVC_R_DOUT      = 8'h20;
  localparam logic [7:0]  FPVC_R_TEXT      = 8'h24;
  localparam logic [7:0]  FPVC_R_SLOTS     = 8'h28;
  // status register bits
  localparam int          FPVC_EV_GOOD     = 0;
  localparam int          FPVC_EV_UNC      = 1;
  localparam int          FPVC_EV_BAD      = 2;
  localparam int          FPVC_EV_TEXT     = 3;
  localparam int          FPVC_EV_TOOLONG  = 4;
  localparam int          FPVC_EV_DIG      = 5;
  localparam int          FPVC_EV_W        = 6;
  localparam logic [31:0] FPVC_CTRL_RST    = 32'h0000_0000;

  typedef enum logic [1:0] {
    FPVC_SLOT_EMPTY = 2'b00,
    FPVC_SLOT_ANA   = 2'b01,
    FPVC_SLOT_DIG   = 2'b10
  } fpvc_slot_t;

  // link frame kinds
  typedef enum logic [1:0] {
    FPVC_FR_ANA  = 2'b00,
    FPVC_FR_DIG  = 2'b01,
    FPVC_FR_TEXT = 2'b10,
    FPVC_FR_CFG  = 2'b11
  } fpvc_frame_t;
endpackage
`default_nettype wire

// File: tb/fieldbus_process_value_codec_test.sv
/*
  Self-checking bench: device and master ends joined by the link;
  Wishbone tasks on the device side, user requests on the master side.
  Assumes design sources and the link checker are compiled first.
*/
`default_nettype none
module fieldbus_process_value_codec_test;
  timeunit 1ns;
  timeprecision 1ns;
  import fpvc_pkg::*;
  logic        core_clk, rst_n, wbCyc, wbStb, wbWe, wbAck, irq, busy;
  logic [7:0]  wbAdr, anaStatus, digLevel, digActive, textChar;
  logic [3:0]  wbSel;
  logic [31:0] wbDatW, wbDatR, anaValue, rxAnaValue, rd, val, expAin, gotAna;
  logic        sendAna, sendDig, textPush, textEnd, rxAnaValid, rxDigValid;
  logic [7:0]  rxAnaStatus, rxDigLevel, rxDigActive, gotAnaSt, gotLvl, gotAct, expSt;
  logic [7:0]  dmQ [$];
  int          failCount = 0, testsRun = 0, cycles = 0, rxSeen = 0, textCnt = 0, was;
  // class, limit bits, expected status, float
  logic [43:0] outRows [12] = '{44'h8_80_40F00000, 44'h9_81_C0F00000, 44'hA_82_3F800000,
    44'hB_83_00000000, 44'h4_48_7F7FFFFF, 44'h5_49_80000001, 44'h6_4A_12345678,
    44'h7_4B_FFFFFFFF, 44'h0_10_40490FDB, 44'h1_11_BF800000, 44'h2_12_00800000,
    44'hC_18_7FC00000};
  logic [7:0]  inSt [6] = '{8'h80, 8'hFF, 8'h7F, 8'h40, 8'h3F, 8'h00};

  fpvc_link_if link ();
  fpvc_device u_fpvc_device (.core_clk(core_clk), .rst_n(rst_n), .link(link),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
    .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .irq(irq));
  fpvc_master u_fpvc_master (.core_clk(core_clk), .rst_n(rst_n), .link(link),
    .sendAna(sendAna), .anaValue(anaValue), .anaStatus(anaStatus), .sendDig(sendDig),
    .digLevel(digLevel), .digActive(digActive), .textPush(textPush),
    .textChar(textChar), .textEnd(textEnd), .busy(busy), .rxAnaValid(rxAnaValid),
    .rxAnaValue(rxAnaValue), .rxAnaStatus(rxAnaStatus), .rxDigValid(rxDigValid),
    .rxDigLevel(rxDigLevel), .rxDigActive(rxDigActive));
  fpvc_link_chk u_fpvc_link_chk (.core_clk(core_clk), .rst_n(rst_n),
    .mdValid(link.mdValid), .mdData(link.mdData), .mdLast(link.mdLast),
    .mdKind(link.mdKind), .dmValid(link.dmValid), .dmData(link.dmData),
    .dmLast(link.dmLast), .dmKind(link.dmKind));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // wire and user-side monitors
  always @(posedge core_clk) begin
    cycles++;
    if (link.dmValid === 1'b1) dmQ.push_back(link.dmData);
    if (link.mdValid === 1'b1 && link.mdKind === FPVC_FR_TEXT) textCnt <= textCnt + 1;
    if (rxAnaValid === 1'b1) begin
      gotAna <= rxAnaValue;
      gotAnaSt <= rxAnaStatus;
    end
    if (rxDigValid === 1'b1) begin
      gotLvl <= rxDigLevel;
      gotAct <= rxDigActive;
    end
    if (rxAnaValid === 1'b1 || rxDigValid === 1'b1) rxSeen <= rxSeen + 1;
    if (cycles == 30000) begin
      failCount++;
      endSim();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      failCount++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic endSim();
    if (failCount == 0 && testsRun > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge core_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbSel <= 4'hF;
    wbDatW <= d;
    do begin
      @(posedge core_clk);
    end while (wbAck !== 1'b1);
    r = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    @(posedge core_clk);
  endtask

  // one request to the master: 0 analog, 1 digital, 2 text character
  task automatic req(input int k, input logic [31:0] v, input logic [7:0] s);
    @(posedge core_clk);
    while (busy !== 1'b0) @(posedge core_clk);
    anaValue <= v;
    anaStatus <= s;
    digLevel <= v[7:0];
    digActive <= s;
    textChar <= s;
    textEnd <= v[0];
    sendAna <= (k == 0);
    sendDig <= (k == 1);
    textPush <= (k == 2);
    @(posedge core_clk);
    sendAna <= 1'b0;
    sendDig <= 1'b0;
    textPush <= 1'b0;
  endtask

  task automatic wait_rx(input int w);
    int n;
    n = 0;
    while (rxSeen == w && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    check(32'(n < 40), 32'h1);
  endtask

  task automatic poll_stat();
    int n;
    n = 0;
    rd = 32'h0;
    while (rd === 32'h0 && n < 20) begin
      wb(1'b0, FPVC_R_STAT, 32'h0, rd);
      n++;
    end
  endtask

  initial begin
    {rst_n, wbCyc, wbStb, wbWe, sendAna, sendDig, textPush, textEnd} = '0;
    {wbAdr, wbSel, wbDatW, anaValue, anaStatus, digLevel, digActive, textChar} = '0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    wb(1'b0, FPVC_R_CTRL, 32'h0, rd);
    check(rd, FPVC_CTRL_RST);
    wb(1'b0, FPVC_R_STAT, 32'h0, rd);
    check(rd, 32'h0);
    wb(1'b0, 8'h3C, 32'h0, rd);
    check(rd, 32'h0);
    check(irq, 1'b0);
    foreach (outRows[i]) begin
      dmQ.delete();
      was = rxSeen;
      wb(1'b1, FPVC_R_AOUT, outRows[i][31:0], rd);
      wb(1'b1, FPVC_R_AOUTST, {28'h0, outRows[i][41:40], outRows[i][43:42]}, rd);
      wait_rx(was);
      check(gotAna, outRows[i][31:0]);
      check(gotAnaSt, outRows[i][39:32]);
      check(32'(dmQ.size()), 32'h5);
      check({dmQ[0], dmQ[1], dmQ[2], dmQ[3]}, outRows[i][31:0]);
      check(dmQ[4], outRows[i][39:32]);
    end
    // incoming status classes at their boundaries
    expAin = 32'h0;
    expSt = 8'h00;
    foreach (inSt[i]) begin
      wb(1'b1, FPVC_R_STAT, 32'h3F, rd);
      val = 32'h4120_0000 + i;
      req(0, val, inSt[i]);
      poll_stat();
      check(rd, 32'h1 << (inSt[i][7] ? FPVC_EV_GOOD : inSt[i][6] ? FPVC_EV_UNC
                          : FPVC_EV_BAD));
      if (inSt[i][7:6] != 2'b00) {expAin, expSt} = {val, inSt[i]};
      wb(1'b0, FPVC_R_AIN, 32'h0, rd);
      check(rd, expAin);
      wb(1'b0, FPVC_R_AINST, 32'h0, rd);
      check(rd, {24'h0, expSt});
    end
    // bad event pending: masked, unmasked, cleared
    wb(1'b1, FPVC_R_MASK, 32'h1, rd);
    wb(1'b0, FPVC_R_STAT, 32'h0, rd);
    check(irq, 1'b0);
    wb(1'b1, FPVC_R_MASK, 32'h4, rd);
    wb(1'b0, FPVC_R_STAT, 32'h0, rd);
    check(irq, 1'b1);
    wb(1'b1, FPVC_R_STAT, 32'h4, rd);
    wb(1'b0, FPVC_R_STAT, 32'h0, rd);
    check(rd, 32'h0);
    check(irq, 1'b0);
    dmQ.delete();
    was = rxSeen;
    wb(1'b1, FPVC_R_DOUT, 32'h3CA5, rd);
    wait_rx(was);
    check(gotLvl, 8'hA5);
    check(gotAct, 8'h3C);
    check({dmQ[0], dmQ[1], 16'(dmQ.size())}, 32'hA53C_0002);
    // bit b drives channel 7-b; only channels 0..3 take master bits
    wb(1'b1, FPVC_R_CTRL, 32'h0F05_3977, rd);
    wb(1'b1, FPVC_R_STAT, 32'h3F, rd);
    req(1, 32'hFF, 8'h55);
    poll_stat();
    check(rd, 32'h1 << FPVC_EV_DIG);
    wb(1'b0, FPVC_R_DIN, 32'h0, rd);
    check(rd, 32'h0A);
    wb(1'b1, FPVC_R_STAT, 32'h3F, rd);
    req(1, 32'h00, 8'h40);
    poll_stat();
    wb(1'b0, FPVC_R_DIN, 32'h0, rd);
    check(rd, 32'h08);
    for (int t = 0; t < 2; t++) begin
      wb(1'b1, FPVC_R_STAT, 32'h3F, rd);
      textCnt = 0;
      for (int c = 0; c < (t ? 45 : 3); c++) req(2, c == (t ? 44 : 2), 8'h41 + c % 26);
      poll_stat();
      check(rd, 32'h1 << FPVC_EV_TEXT);
      check(textCnt, t ? FPVC_TEXT_MAX : 3);
    end
    dmQ.delete();
    wb(1'b1, FPVC_R_SLOTS, 32'h21, rd);
    for (int n = 0; n < 30 && dmQ.size() < 3; n++) @(posedge core_clk);
    check({dmQ[0], dmQ[1], dmQ[2], 8'(dmQ.size())}, 32'h010A_FF03);
    // second reset in mid-run
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    wb(1'b0, FPVC_R_CTRL, 32'h0, rd);
    check(rd, FPVC_CTRL_RST);
    wb(1'b0, FPVC_R_STAT, 32'h0, rd);
    check(rd, 32'h0);
    check(irq, 1'b0);
    endSim();
  end
endmodule
`default_nettype wire

// File: tb/fpvc_link_chk.sv
/*
  Checker for the byte link: frame lengths, framing and status codes.
  Assumes the bench instantiates it beside the link, one clock domain.
*/
`default_nettype none
module fpvc_link_chk (
  // clock and reset
  input wire logic                  core_clk,
  input wire logic                  rst_n,
  // master to device
  input wire logic                  mdValid,
  input wire logic [7:0]            mdData,
  input wire logic                  mdLast,
  input wire fpvc_pkg::fpvc_frame_t mdKind,
  // device to master
  input wire logic                  dmValid,
  input wire logic [7:0]            dmData,
  input wire logic                  dmLast,
  input wire fpvc_pkg::fpvc_frame_t dmKind
);
  import fpvc_pkg::*;
  logic [7:0] dmCnt_q;
  logic [7:0] mdCnt_q;
  // byte index inside the running frame of each direction
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dmCnt_q <= 8'h00;
      mdCnt_q <= 8'h00;
    end else begin
      if (dmValid) dmCnt_q <= dmLast ? 8'h00 : dmCnt_q + 8'h01;
      if (mdValid) mdCnt_q <= mdLast ? 8'h00 : mdCnt_q + 8'h01;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_reset_quiet: assert property ($rose(rst_n) |-> !dmValid && !mdValid)
    else $error("link busy right after reset");
  a_ana_len_dm: assert property (
    dmValid && dmKind == FPVC_FR_ANA && dmLast |-> dmCnt_q == 8'h04)
    else $error("device analog frame length wrong");
  a_ana_len_md: assert property (
    mdValid && mdKind == FPVC_FR_ANA && mdLast |-> mdCnt_q == 8'h04)
    else $error("master analog frame length wrong");
  a_dm_dense: assert property (
    dmValid && !dmLast && dmKind != FPVC_FR_CFG |=> dmValid && $stable(dmKind))
    else $error("device frame broken up");
  a_md_dense: assert property (
    mdValid && !mdLast && mdKind != FPVC_FR_TEXT |=> mdValid && $stable(mdKind))
    else $error("master frame broken up");
  a_dig_len_dm: assert property (
    dmValid && dmKind == FPVC_FR_DIG && dmLast |-> dmCnt_q == 8'h01)
    else $error("device digital frame length wrong");
  a_dig_len_md: assert property (
    mdValid && mdKind == FPVC_FR_DIG && mdLast |-> mdCnt_q == 8'h01)
    else $error("master digital frame length wrong");
  a_status_code: assert property (
    dmValid && dmKind == FPVC_FR_ANA && dmLast
      |-> dmData inside {[8'h10:8'h13], 8'h18, [8'h48:8'h4B], [8'h80:8'h83]})
    else $error("outgoing status code out of set");
  a_cfg_no_empty: assert property (
    dmValid && dmKind == FPVC_FR_CFG && dmData != 8'hFF
      |-> dmData[1:0] != 2'b00 && dmData[7:4] == 4'h0)
    else $error("config byte for empty slot");
  a_cfg_pad_last: assert property (
    dmValid && dmKind == FPVC_FR_CFG && dmData == 8'hFF |-> dmLast)
    else $error("config filler not last");
  a_text_max: assert property (
    mdValid && mdKind == FPVC_FR_TEXT |-> int'(mdCnt_q) < FPVC_TEXT_MAX)
    else $error("event text too long");
endmodule
`default_nettype wire
